// >>> src/fsk_cid_pkg.sv
// constants, register map and pin bundles for the caller-identity serial port
// assumes a 20 MHz aclk and an analog front end that delivers logic levels
//
// Notes on behaviour
// - demodulated mark gives 1, space gives 0; both tone plans accepted.
// - receiver takes 1200 baud serial bits within 12 baud either way.
// - each demodulated bit reaches serial data output within 5 ms; passed through only while the shifter is idle.
// - carrier present goes low within 25 ms of valid modulation.
// - carrier present returns high no sooner than 8 ms; 8 ms hysteresis.
// - mode 0 bit clock driven by device, phases 415 to 417 us.
// - mode 0 data stable 6 us before and after the bit clock edge.
// - mode 0 byte ready low 416 us, 416 us after last clock rise.
// - alert tone reported present 0.5 to 10 ms after it starts.
// - alert tone reported absent 0.1 to 8 ms after it stops.
// - all serial timing derives from one reference clock.
// - external 15 ms guard gives tone-absent total of 15 to 25 ms.
// - ring trigger output follows the ringing envelope.
// - ringing alone never asserts carrier present.
package fsk_cid_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_KHZ         = 20000;
  localparam int HALF_BIT_US     = 416;
  localparam int HALF_BIT_CYC    = HALF_BIT_US * CLK_KHZ / 1000;
  localparam int BAUD            = 1200;
  localparam int BIT_CYC         = CLK_KHZ * 1000 / BAUD;
  localparam int CARRIER_ON_MS   = 10;
  localparam int CARRIER_ON_CYC  = CARRIER_ON_MS * CLK_KHZ;
  localparam int CARRIER_OFF_MS  = 8;
  localparam int CARRIER_OFF_CYC = CARRIER_OFF_MS * CLK_KHZ;
  localparam int ALERT_ON_US     = 1000;
  localparam int ALERT_ON_CYC    = ALERT_ON_US * CLK_KHZ / 1000;
  localparam int ALERT_OFF_US    = 1000;
  localparam int ALERT_OFF_CYC   = ALERT_OFF_US * CLK_KHZ / 1000;
  localparam int CNT_W           = 24;
  localparam int BITS_PER_BYTE   = 8;

  // ==========================================================================
  // register map
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_RXDATA  = 4'h8;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam int          CTRL_MODE   = 0;
  localparam int          CTRL_DEMOD  = 1;
  localparam int          ST_CARRIER  = 0;
  localparam int          ST_TONE     = 1;
  localparam int          ST_RING     = 2;
  localparam int          ST_AVAIL    = 3;
  localparam int          ST_OVERRUN  = 4;
  localparam int          ST_FRAMEERR = 5;
  localparam int          ST_MODE     = 6;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // pin bundles
  typedef struct packed {
    logic mark_bit;
    logic band_energy;
    logic alert_tone;
    logic ring_env;
    logic host_clock;
  } line_in_type;

  typedef struct packed {
    logic serial_data;
    logic serial_bit_clock;
    logic serial_bit_clock_oe;
    logic byte_ready_strobe_n;
    logic carrier_present_n;
    logic tone_valid_delayed;
    logic ring_trigger_out;
  } line_out_type;

endpackage

// >>> src/fsk_cid_port.sv
// caller-identity serial port: byte receiver, 3-wire shifter, detectors
// assumes line_in pins are asynchronous levels; registers via AXI4-Lite
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module fsk_cid_port #(
  parameter int HALF_BIT_CYCLES    = fsk_cid_pkg::HALF_BIT_CYC,
  parameter int BIT_CYCLES         = fsk_cid_pkg::BIT_CYC,
  parameter int CARRIER_ON_CYCLES  = fsk_cid_pkg::CARRIER_ON_CYC,
  parameter int CARRIER_OFF_CYCLES = fsk_cid_pkg::CARRIER_OFF_CYC,
  parameter int ALERT_ON_CYCLES    = fsk_cid_pkg::ALERT_ON_CYC,
  parameter int ALERT_OFF_CYCLES   = fsk_cid_pkg::ALERT_OFF_CYC
)(
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [fsk_cid_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                             awvalid,
  output      logic                             awready,
  input  wire logic [31:0]                      wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output      logic                             wready,
  output      logic [1:0]                       bresp,
  output      logic                             bvalid,
  input  wire logic                             bready,
  input  wire logic [fsk_cid_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                             arvalid,
  output      logic                             arready,
  output      logic [31:0]                      rdata,
  output      logic [1:0]                       rresp,
  output      logic                             rvalid,
  input  wire logic                             rready,
  input  wire fsk_cid_pkg::line_in_type         line_in,
  output      fsk_cid_pkg::line_out_type        line_out
);
  import fsk_cid_pkg::*;

  // ==========================================================================
  // elaboration checks
  if (HALF_BIT_CYCLES < 2 || BIT_CYCLES < 4 ||
      CARRIER_ON_CYCLES < 1 || CARRIER_OFF_CYCLES < 1 ||
      ALERT_ON_CYCLES < 1 || ALERT_OFF_CYCLES < 1)
  begin : g_bad_small
    $error("timing parameter too small");
  end
  if (HALF_BIT_CYCLES >= 2**CNT_W || BIT_CYCLES >= 2**CNT_W ||
      CARRIER_ON_CYCLES >= 2**CNT_W || CARRIER_OFF_CYCLES >= 2**CNT_W ||
      ALERT_ON_CYCLES >= 2**CNT_W || ALERT_OFF_CYCLES >= 2**CNT_W)
  begin : g_bad_large
    $error("timing parameter exceeds counter width");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  typedef enum logic [2:0] {TX_IDLE, TX_LOW, TX_HIGH, TX_READY, TX_HOLD}
    tx_state_type;

  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] MID_LAST  = CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [2:0]       LAST_BIT  = 3'(BITS_PER_BYTE - 1);

  function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[3:2];
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_RXDATA);
  endfunction

  // ==========================================================================
  // pin synchronisers
  line_in_type sync1_q;
  line_in_type sync2_q;
  logic        host_clk_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      host_clk_q <= 1'b0;
    end
    else
    begin
      sync1_q    <= line_in;
      sync2_q    <= sync1_q;
      host_clk_q <= sync2_q.host_clock;
    end
  end

  logic [1:0] ctrl_q;
  wire        mode1     = ctrl_q[CTRL_MODE];
  wire        demod_en  = ctrl_q[CTRL_DEMOD];
  wire        host_rise = sync2_q.host_clock && !host_clk_q;
  // disabled demodulator idles at mark so speech never frames bytes
  wire        rx_bit    = demod_en ? sync2_q.mark_bit : 1'b1;

  // ==========================================================================
  // carrier and alert qualifiers
  wire [1:0] det_raw = {sync2_q.alert_tone, sync2_q.band_energy};
  wire [1:0] det;

  for (genvar g = 0; g < 2; g++)
  begin : g_qual
    localparam int ON_C  = (g == 0) ? CARRIER_ON_CYCLES  : ALERT_ON_CYCLES;
    localparam int OFF_C = (g == 0) ? CARRIER_OFF_CYCLES : ALERT_OFF_CYCLES;
    logic [CNT_W-1:0] cnt_q;
    logic             st_q;
    wire              differ = det_raw[g] != st_q;
    wire [CNT_W-1:0]  limit  = st_q ? CNT_W'(OFF_C - 1) : CNT_W'(ON_C - 1);

    // change only after a full run of the opposite level: hysteresis
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cnt_q <= '0;
        st_q  <= 1'b0;
      end
      else if (!differ)
        cnt_q <= '0;
      else if (cnt_q == limit)
      begin
        cnt_q <= '0;
        st_q  <= det_raw[g];
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
    assign det[g] = st_q;
  end

  wire carrier = det[0];
  wire tone_ok = det[1];

  // ==========================================================================
  // byte receiver
  rx_state_type     rx_st_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [2:0]       rx_idx_q;
  logic [7:0]       rx_sh_q;
  logic [7:0]       rx_byte_q;
  logic             rx_done_q;
  logic             rx_ferr_q;

  wire rx_mid  = rx_cnt_q == MID_LAST;
  wire rx_full = rx_cnt_q == BIT_LAST;

  // sampling mid-bit leaves margin for 1 % rate error over ten bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= '0;
      rx_idx_q  <= '0;
      rx_sh_q   <= '0;
      rx_byte_q <= '0;
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end
    else
    begin
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_cnt_q  <= rx_cnt_q + 1'b1;
      case (rx_st_q)
        RX_IDLE:
        begin
          rx_cnt_q <= '0;
          if (!rx_bit && carrier)
            rx_st_q <= RX_START;
        end
        RX_START:
          if (rx_mid)
          begin
            rx_cnt_q <= '0;
            rx_idx_q <= '0;
            rx_st_q  <= rx_bit ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_full)
          begin
            rx_cnt_q <= '0;
            rx_sh_q  <= {rx_bit, rx_sh_q[7:1]};
            rx_idx_q <= rx_idx_q + 1'b1;
            if (rx_idx_q == LAST_BIT)
              rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_full)
          begin
            rx_st_q   <= RX_IDLE;
            rx_done_q <= rx_bit;
            rx_ferr_q <= !rx_bit;
            if (rx_bit)
              rx_byte_q <= rx_sh_q;
          end
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // 3-wire shifter
  tx_state_type     tx_st_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [2:0]       tx_idx_q;
  logic [7:0]       tx_sh_q;

  wire tx_half = tx_cnt_q == HALF_LAST;
  wire tx_busy = tx_st_q != TX_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_q  <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_idx_q <= '0;
      tx_sh_q  <= '0;
    end
    else
    begin
      tx_cnt_q <= tx_half ? '0 : tx_cnt_q + 1'b1;
      case (tx_st_q)
        TX_IDLE:
        begin
          tx_cnt_q <= '0;
          tx_idx_q <= '0;
          if (rx_done_q)
          begin
            tx_sh_q <= rx_byte_q;
            tx_st_q <= mode1 ? TX_HOLD : TX_LOW;
          end
        end
        TX_LOW:
          if (tx_half)
            tx_st_q <= TX_HIGH;
        TX_HIGH:
          if (tx_half)
          begin
            // data moves on the falling edge, a full phase from either rise
            tx_sh_q  <= tx_sh_q >> 1;
            tx_idx_q <= tx_idx_q + 1'b1;
            tx_st_q  <= (tx_idx_q == LAST_BIT) ? TX_READY : TX_LOW;
          end
        TX_READY:
          if (tx_half)
            tx_st_q <= TX_IDLE;
        TX_HOLD:
          if (host_rise)
          begin
            // host keeps its clock low around the strobe edge
            tx_sh_q  <= tx_sh_q >> 1;
            tx_idx_q <= tx_idx_q + 1'b1;
            if (tx_idx_q == LAST_BIT)
              tx_st_q <= TX_IDLE;
          end
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // pin outputs
  line_out_type out_d;
  line_out_type out_q;

  // idle shifter passes the live demodulated bit straight through
  assign out_d.serial_data         = tx_busy ? tx_sh_q[0] : rx_bit;
  assign out_d.serial_bit_clock    = !mode1 && tx_st_q == TX_HIGH;
  assign out_d.serial_bit_clock_oe = !mode1;
  assign out_d.byte_ready_strobe_n = !(tx_st_q == TX_READY ||
                                       (tx_st_q == TX_HOLD &&
                                        tx_idx_q == '0));
  assign out_d.carrier_present_n   = !carrier;
  assign out_d.tone_valid_delayed  = tone_ok;
  assign out_d.ring_trigger_out    = sync2_q.ring_env;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_q <= '{byte_ready_strobe_n: 1'b1, carrier_present_n: 1'b1,
                 serial_bit_clock_oe: 1'b1, serial_data: 1'b1,
                 default: 1'b0};
    else
      out_q <= out_d;
  end
  assign line_out = out_q;

  // ==========================================================================
  // AXI4-Lite slave
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              avail_q;
  logic              overrun_q;
  logic              ferr_q;
  logic [31:0]       status_word;

  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  wire aw_take  = awvalid && awready;
  wire w_take   = wvalid && wready;
  wire ar_take  = arvalid && arready;
  wire do_write = aw_have_q && w_have_q;
  wire wr_low   = do_write && w_strb_q[0];
  wire wr_ctrl  = wr_low && aw_addr_q == REG_CTRL;
  wire wr_stat  = wr_low && aw_addr_q == REG_STATUS;
  wire rd_pop   = ar_take && araddr == REG_RXDATA;
  wire ovr_set  = rx_done_q && (avail_q || tx_busy);

  always_comb
  begin
    status_word              = '0;
    status_word[ST_CARRIER]  = carrier;
    status_word[ST_TONE]     = tone_ok;
    status_word[ST_RING]     = sync2_q.ring_env;
    status_word[ST_AVAIL]    = avail_q;
    status_word[ST_OVERRUN]  = overrun_q;
    status_word[ST_FRAMEERR] = ferr_q;
    status_word[ST_MODE]     = mode1;
  end

  wire [31:0] rd_mux = (reg_index(araddr) == reg_index(REG_CTRL)) ?
                         {30'h0, ctrl_q} :
                       (reg_index(araddr) == reg_index(REG_STATUS)) ?
                         status_word : {24'h0, rx_byte_q};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_q <= '0;
      aw_have_q <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      ctrl_q    <= CTRL_RESET;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_q <= awaddr;
        aw_have_q <= 1'b1;
      end
      if (w_take)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_have_q <= 1'b1;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= reg_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
      if (wr_ctrl)
        ctrl_q <= w_data_q[1:0];
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= reg_mapped(araddr) ? rd_mux : 32'h0;
      end
      else if (rvalid_q && rready)
        rvalid_q <= 1'b0;
    end
  end

  // a new event outranks a clear arriving in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      avail_q   <= 1'b0;
      overrun_q <= 1'b0;
      ferr_q    <= 1'b0;
    end
    else
    begin
      avail_q   <= rx_done_q || (avail_q && !rd_pop);
      overrun_q <= ovr_set ||
                   (overrun_q && !(wr_stat && w_data_q[ST_OVERRUN]));
      ferr_q    <= rx_ferr_q ||
                   (ferr_q && !(wr_stat && w_data_q[ST_FRAMEERR]));
    end
  end

endmodule

// >>> sim/fsk_cid_port_chk.sv
// checker: pin timing of the caller-identity serial port
// assumes it is bound into fsk_cid_port; run counters watch raw pins
`timescale 1ns/10ps
module fsk_cid_port_chk
  import fsk_cid_pkg::*;
#(
  parameter int HALF_BIT_CYCLES    = fsk_cid_pkg::HALF_BIT_CYC,
  parameter int CARRIER_ON_CYCLES  = fsk_cid_pkg::CARRIER_ON_CYC,
  parameter int CARRIER_OFF_CYCLES = fsk_cid_pkg::CARRIER_OFF_CYC,
  parameter int ALERT_ON_CYCLES    = fsk_cid_pkg::ALERT_ON_CYC,
  parameter int ALERT_OFF_CYCLES   = fsk_cid_pkg::ALERT_OFF_CYC
)(
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire fsk_cid_pkg::line_in_type  line_in,
  input wire fsk_cid_pkg::line_out_type line_out
);
  // ==========================================================================
  // run lengths; slack of 8 covers the synchronisers and output flop
  int on_q, off_q, ton_q, toff_q, hi_q, lo_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      on_q   <= 0;
      off_q  <= 0;
      ton_q  <= 0;
      toff_q <= 0;
      hi_q   <= 0;
      lo_q   <= 0;
    end
    else
    begin
      on_q   <= line_in.band_energy ? on_q + 1 : 0;
      off_q  <= line_in.band_energy ? 0 : off_q + 1;
      ton_q  <= line_in.alert_tone ? ton_q + 1 : 0;
      toff_q <= line_in.alert_tone ? 0 : toff_q + 1;
      hi_q   <= line_out.serial_bit_clock ? hi_q + 1 : 0;
      lo_q   <= line_out.byte_ready_strobe_n ? 0 : lo_q + 1;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ring_follow: assert property (
    $past(aresetn, 3) |->
    line_out.ring_trigger_out == $past(line_in.ring_env, 3))
    else $error("ring trigger lags ring envelope wrongly");
  a_carrier_qual: assert property (
    $fell(line_out.carrier_present_n) |-> on_q >= CARRIER_ON_CYCLES)
    else $error("carrier present without qualified energy");
  a_carrier_late: assert property (
    on_q == CARRIER_ON_CYCLES + 8 |-> !line_out.carrier_present_n)
    else $error("carrier present too late");
  a_carrier_hold: assert property (
    $rose(line_out.carrier_present_n) |-> off_q >= CARRIER_OFF_CYCLES)
    else $error("carrier released too early");
  a_carrier_drop: assert property (
    off_q == CARRIER_OFF_CYCLES + 8 |-> line_out.carrier_present_n)
    else $error("carrier never released");
  a_tone_min: assert property (
    $rose(line_out.tone_valid_delayed) |-> ton_q >= ALERT_ON_CYCLES)
    else $error("tone reported too early");
  a_tone_late: assert property (
    ton_q == ALERT_ON_CYCLES + 8 |-> line_out.tone_valid_delayed)
    else $error("tone reported too late");
  a_tone_drop: assert property (
    $fell(line_out.tone_valid_delayed) |-> toff_q >= ALERT_OFF_CYCLES)
    else $error("tone absence reported too early");
  a_clk_high: assert property (
    $fell(line_out.serial_bit_clock) |-> hi_q == HALF_BIT_CYCLES)
    else $error("bit clock high phase wrong");
  a_data_stable: assert property (
    line_out.serial_bit_clock_oe && line_out.serial_bit_clock |->
    $stable(line_out.serial_data))
    else $error("data moved while bit clock high");
  a_strobe_delay: assert property (
    $fell(line_out.byte_ready_strobe_n) && line_out.serial_bit_clock_oe
    |-> $fell(line_out.serial_bit_clock) && hi_q == HALF_BIT_CYCLES)
    else $error("strobe not one half bit after last clock rise");
  a_strobe_width: assert property (
    $rose(line_out.byte_ready_strobe_n) && line_out.serial_bit_clock_oe
    |-> lo_q == HALF_BIT_CYCLES)
    else $error("strobe low time wrong");
  c_carrier: cover property ($fell(line_out.carrier_present_n));
  c_tone: cover property ($rose(line_out.tone_valid_delayed));
  c_strobe0: cover property ($rose(line_out.byte_ready_strobe_n)
    && line_out.serial_bit_clock_oe);
  c_strobe1: cover property ($rose(line_out.byte_ready_strobe_n)
    && !line_out.serial_bit_clock_oe);
endmodule

bind fsk_cid_port fsk_cid_port_chk #(
  .HALF_BIT_CYCLES(HALF_BIT_CYCLES),
  .CARRIER_ON_CYCLES(CARRIER_ON_CYCLES),
  .CARRIER_OFF_CYCLES(CARRIER_OFF_CYCLES),
  .ALERT_ON_CYCLES(ALERT_ON_CYCLES),
  .ALERT_OFF_CYCLES(ALERT_OFF_CYCLES)
) chk_u (.aclk(aclk), .aresetn(aresetn), .line_in(line_in),
  .line_out(line_out));

// >>> sim/cid_host_model.sv
// host model: reads bytes from the 3-wire port in either mode
// assumes host_mode follows the mode bit written into the port
`timescale 1ns/10ps
module cid_host_model
  import fsk_cid_pkg::*;
(
  input  wire logic                      host_mode,
  input  wire fsk_cid_pkg::line_out_type line_out,
  output      logic                      host_clock,
  output      logic [7:0]                rx_byte,
  output      int                        rx_count
);
  logic [7:0] sh;
  initial
  begin
    host_clock = 1'b0;
    rx_byte = 8'h00;
    rx_count = 0;
    sh = 8'h00;
  end
  // ==========================================================================
  // device clock: sample as the clock rises, lsb first
  always @(posedge line_out.serial_bit_clock)
    if (!host_mode)
      sh = {line_out.serial_data, sh[7:1]};
  // host clock runs only inside a frame, 400 ns period
  always @(negedge line_out.byte_ready_strobe_n)
  begin
    if (host_mode)
    begin
      #537;
      for (int i = 0; i < 8; i++)
      begin
        sh = {line_out.serial_data, sh[7:1]};
        host_clock = 1'b1;
        #200;
        host_clock = 1'b0;
        #200;
      end
    end
    rx_byte = sh;
    rx_count++;
  end
endmodule

// >>> sim/test_fsk_cid_serial_port.sv
// testbench: register bus, detectors and byte path in both modes
// assumes the host model on the far side and the checker bound in
`timescale 1ns/10ps
module test_fsk_caller_id_serial_port;
  import fsk_cid_pkg::*;
  localparam int HB = 8, BC = 32, CON = 20, COFF = 16, AON = 10, AOFF = 10;
  logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, host_mode;
  logic [3:0]   awaddr, araddr, wstrb;
  logic [31:0]  wdata, rdata, rd, seed;
  logic [1:0]   bresp, rresp, rs;
  logic         mark_bit, band_energy, alert_tone, ring_env, host_clock;
  line_in_type  line_in;
  line_out_type line_out;
  logic [7:0]   rx_byte;
  int           rx_count, failures, checks_done, cycles, n, w, e;
  int           exp_q[$];
  assign line_in = {mark_bit, band_energy, alert_tone, ring_env, host_clock};

  fsk_cid_port #(.HALF_BIT_CYCLES(HB), .BIT_CYCLES(BC),
    .CARRIER_ON_CYCLES(CON), .CARRIER_OFF_CYCLES(COFF),
    .ALERT_ON_CYCLES(AON), .ALERT_OFF_CYCLES(AOFF)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_in(line_in),
    .line_out(line_out));
  cid_host_model host_u (.host_mode(host_mode), .line_out(line_out),
    .host_clock(host_clock), .rx_byte(rx_byte), .rx_count(rx_count));

  // ==========================================================================
  // clock, watchdog, reporting
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      $display("[ERR] %0t run hung", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // ==========================================================================
  // bus and line drivers
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd, bd;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd)
    begin
      @(posedge aclk);
      if (awready) ad = 1'b1;
      if (wready) wd = 1'b1;
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      if (bvalid) bd = 1'b1;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) got = 1'b1;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // start 0, eight data bits lsb first, stop 1
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge aclk);
    for (int i = 0; i < 10; i++)
    begin
      mark_bit <= fr[i];
      repeat (BC) @(posedge aclk);
    end
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {band_energy, alert_tone, ring_env, host_mode} = '0;
    mark_bit = 1'b1;
    {failures, checks_done, cycles} = '0;
    seed = 32'h5419;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({25'h0, line_out}, 32'h5C, "pins after reset");
    axi_rd(REG_CTRL);
    chk(rd, 32'h0, "control after reset");
    axi_rd(REG_STATUS);
    chk(rd, 32'h0, "status after reset");
    axi_rd(4'hC);
    chk(rd, 32'h0, "unmapped read data");
    chk(rs, RESP_SLVERR, "unmapped read response");
    axi_wr(4'hC, 32'hFF);
    chk(rs, RESP_SLVERR, "unmapped write");
    $display("test registers finished");
    ring_env <= 1'b1;
    repeat (CON + 10) @(posedge aclk);
    chk(line_out.ring_trigger_out, 1, "ring follows");
    chk(line_out.carrier_present_n, 1, "ring alone");
    axi_rd(REG_STATUS);
    chk(rd, 32'h4, "status ring");
    ring_env <= 1'b0;
    alert_tone <= 1'b1;
    repeat (AON - 1) @(posedge aclk);
    chk(line_out.tone_valid_delayed, 0, "tone early");
    repeat (10) @(posedge aclk);
    chk(line_out.tone_valid_delayed, 1, "tone present");
    alert_tone <= 1'b0;
    repeat (AOFF - 1) @(posedge aclk);
    chk(line_out.tone_valid_delayed, 1, "tone held");
    repeat (8) @(posedge aclk);
    chk(line_out.tone_valid_delayed, 0, "tone absent");
    $display("test detectors finished");
    axi_wr(REG_CTRL, 32'h2);
    band_energy <= 1'b1;
    repeat (CON - 1) @(posedge aclk);
    chk(line_out.carrier_present_n, 1, "carrier early");
    repeat (10) @(posedge aclk);
    chk(line_out.carrier_present_n, 0, "carrier present");
    for (int m = 0; m < 2; m++)
    begin
      host_mode <= m[0];
      axi_wr(REG_CTRL, {30'h0, 1'b1, m[0]});
      for (int k = 0; k < 3; k++)
      begin
        seed = xs(seed);
        exp_q.push_back(int'(seed[7:0]));
        n = rx_count;
        send_byte(seed[7:0]);
        w = 0;
        while (rx_count == n && w < 600)
        begin
          @(posedge aclk);
          w++;
        end
        e = exp_q.pop_front();
        chk(rx_byte, e[7:0], "byte at host");
        axi_rd(REG_RXDATA);
        chk(rd, e, "byte register");
        axi_rd(REG_STATUS);
        chk(rd & 32'h49, {m[0], 6'h01}, "status after byte");
      end
      $display("test byte path finished");
    end
    band_energy <= 1'b0;
    repeat (COFF - 1) @(posedge aclk);
    chk(line_out.carrier_present_n, 0, "carrier held");
    repeat (10) @(posedge aclk);
    chk(line_out.carrier_present_n, 1, "carrier released");
    axi_wr(REG_CTRL, 32'h1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_CTRL);
    chk(rd, 32'h0, "control after second reset");
    $display("test end finished");
    end_of_test();
  end
endmodule
